/* rtl/ddr_sram_read_port_interface.sv */
`timescale 1ns/10ps
// Summary of operation
// - Address is captured on positive input clock rise during active operations.
// - Address ignored at a capture edge whose port is deselected.
// - Address is 19, 18 or 17 bits by word width; here 18.
// - Memory is four equal sub-arrays, each a quarter of the words.
// - Read data launched on rising edges of both output clocks.
// - Single clock mode launches read data on input clock rises instead.
// - Read outputs go high impedance at a positive launch edge once no read is pending.
// - Active-low read select sampled on input clock rise starts a read.
// - Deselect mid-read still lets the pending read finish.
// - After deselect, drivers turn off after next positive output clock rise; in single clock mode, after next positive input clock rise.
// - Each read delivers four sequential transfers.
// - All accesses start on positive input clock rise.
// - Negative input clock rise captures double-data-rate inputs.
// - Active-low write select starts a write; deselected write data ignored.
// - Write data sampled on rises of both input clocks.
module ddr_sram_read_port_interface
    import sram_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic single_clk_mode,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic read_port_sel_n,
    input wire logic write_port_sel_n,
    input wire logic [DATA_W-1:0] d_in,
    output logic [DATA_W-1:0] q_out,
    output logic q_oe
);
    function automatic logic rose(input logic cur, input logic prev);
        return cur && !prev;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Clock edge detection
    logic k_ff;
    logic kn_ff;
    logic c_ff;
    logic cn_ff;
    wire k_rise = rose(k_clk, k_ff);
    wire kn_rise = rose(k_clk_n, kn_ff);
    wire c_rise = rose(c_clk, c_ff);
    wire cn_rise = rose(c_clk_n, cn_ff);

    wire launch_p = single_clk_mode ? k_rise : c_rise;
    wire launch_n = single_clk_mode ? kn_rise : cn_rise;
    wire launch = launch_p || launch_n;

    ////////////////////////////////////////////////////////////////////////////
    // Address slot and port selection
    slot_e slot_ff;
    wire read_slot = k_rise && (slot_ff == READ_SLOT);
    wire write_slot = k_rise && (slot_ff == WRITE_SLOT);

    xfer_e rd_state_ff;
    xfer_e wr_state_ff;
    beat_s rd_beat_ff;
    beat_s wr_beat_ff;
    wire rd_start = read_slot && !read_port_sel_n && (rd_state_ff == XFER_IDLE);
    // Low select starts write
    // Last beat and next capture may share a k rise
    wire wr_start = write_slot && !write_port_sel_n && ((wr_state_ff == XFER_IDLE) || wr_done);

    ////////////////////////////////////////////////////////////////////////////
    // Storage: four sub-arrays
    // Beat picks sub-array
    logic [DATA_W-1:0] mem [SUB_ARRAYS][SUB_DEPTH];

    wire wr_edge = (wr_state_ff == XFER_BURST) && (k_rise || kn_rise);

    always_ff @(posedge ref_clk) begin
        if (wr_edge) begin
            mem[wr_beat_ff.beat][wr_beat_ff.addr] <= d_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read burst into output buffer
    word_s fifo_in;
    word_s fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    wire rd_push = (rd_state_ff == XFER_BURST);
    // Back-pressure stalls the burst, never drops a beat
    wire rd_adv = rd_push && fifo_in_ready;
    wire rd_done = rd_adv && (rd_beat_ff.beat == CNT_LAST);
    wire wr_done = wr_edge && (wr_beat_ff.beat == CNT_LAST);
    wire q_pop = launch && fifo_out_valid;
    assign fifo_in.data = mem[rd_beat_ff.beat][rd_beat_ff.addr];

    sync_fifo #(
        .WIDTH($bits(word_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_read_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_data(fifo_in),
        .in_valid(rd_push),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(launch)
    );

    wire rd_pending = rd_push || fifo_out_valid;
    wire q_off = launch_p && !rd_pending;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            k_ff <= 1'b0;
            kn_ff <= 1'b0;
            c_ff <= 1'b0;
            cn_ff <= 1'b0;
            slot_ff <= READ_SLOT;
        end else begin
            k_ff <= k_clk;
            kn_ff <= k_clk_n;
            c_ff <= c_clk;
            cn_ff <= c_clk_n;
            slot_ff <= k_rise ? ((slot_ff == READ_SLOT) ? WRITE_SLOT : READ_SLOT) : slot_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_state_ff <= XFER_IDLE;
            rd_beat_ff <= '{addr: ADDR_RST, beat: CNT_RST};
        end else if (rd_start) begin
            rd_state_ff <= XFER_BURST;
            rd_beat_ff <= '{addr: addr, beat: CNT_RST};
        end else if (rd_adv) begin
            rd_state_ff <= rd_done ? XFER_IDLE : XFER_BURST;
            rd_beat_ff.beat <= rd_beat_ff.beat + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state_ff <= XFER_IDLE;
            wr_beat_ff <= '{addr: ADDR_RST, beat: CNT_RST};
        end else if (wr_start) begin
            wr_state_ff <= XFER_BURST;
            wr_beat_ff <= '{addr: addr, beat: CNT_RST};
        end else if (wr_edge) begin
            wr_state_ff <= wr_done ? XFER_IDLE : XFER_BURST;
            wr_beat_ff.beat <= wr_beat_ff.beat + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_out <= DATA_RST;
            q_oe <= 1'b0;
        end else if (q_pop) begin
            q_out <= fifo_out.data;
            q_oe <= 1'b1;
        end else if (q_off) begin
            q_oe <= 1'b0;
        end
    end
endmodule

/* rtl/sram_port_pkg.sv */
package sram_port_pkg;
    // x18 word variant
    localparam int ADDR_W = 18;
    localparam int DATA_W = 18;
    localparam int SUB_ARRAYS = 4;
    localparam int BURST_LEN = 4;
    localparam int CNT_W = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int SUB_DEPTH = 2 ** ADDR_W;
    localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
    localparam logic [CNT_W-1:0] CNT_LAST = 2'h3;
    localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0_0000;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;

    typedef enum logic {
        READ_SLOT,
        WRITE_SLOT
    } slot_e;

    typedef enum logic {
        XFER_IDLE,
        XFER_BURST
    } xfer_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [CNT_W-1:0] beat;
    } beat_s;

    typedef struct packed {
        logic [DATA_W-1:0] data;
    } word_s;
endpackage

/* rtl/sync_fifo.sv */
`timescale 1ns/10ps
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [PTR_W:0] count_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_ff != (PTR_W+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = store[rd_ptr_ff];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            store[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            wr_ptr_ff <= push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
            rd_ptr_ff <= pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
            count_ff <= count_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end
endmodule

/* test/sram_port_props.sv */
`timescale 1ns/10ps
module sram_port_props
    import sram_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic single_clk_mode,
    input wire logic read_port_sel_n,
    input wire logic [DATA_W-1:0] q_out,
    input wire logic q_oe
);
logic [3:0] prev_ff;
logic slot_ff;
logic [4:0] idle_ff;
wire [3:0] rise = {k_clk, k_clk_n, c_clk, c_clk_n} & ~prev_ff;
wire pos_l = single_clk_mode ? rise[3] : rise[1];
wire launch = pos_l | (single_clk_mode ? rise[2] : rise[0]);
wire rd_take = rise[3] & ~slot_ff & ~read_port_sel_n;
always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        prev_ff <= 4'h0;
        slot_ff <= 1'b0;
        idle_ff <= 5'h1f;
    end else begin
        prev_ff <= {k_clk, k_clk_n, c_clk, c_clk_n};
        slot_ff <= slot_ff ^ rise[3];
        idle_ff <= rd_take ? 5'h00 : idle_ff + {4'h0, idle_ff != 5'h1f};
    end
end
default clocking @(posedge ref_clk); endclocking
default disable iff (!rst_n);
sequence rd_desel;
    rd_take ##1 read_port_sel_n;
endsequence
q_hold_a: assert property (!launch |=> $stable(q_out))
    else $error("q_out moved off launch");
oe_hold_a: assert property (!launch |=> $stable(q_oe))
    else $error("q_oe moved off launch");
single_mode_a: assert property (single_clk_mode && rise[3:2] == 2'h0 |=> $stable(q_out))
    else $error("output clock used in single mode");
oe_fall_a: assert property ($fell(q_oe) |-> $past(pos_l))
    else $error("q_oe fell off positive launch");
oe_off_a: assert property (q_oe && pos_l && idle_ff > 5'h10 |=> !q_oe)
    else $error("q_oe kept after idle");
read_drive_a: assert property (rd_take |-> ##[1:15] q_oe)
    else $error("read not driven");
pending_a: assert property (rd_desel |-> ##[0:14] q_oe)
    else $error("pending read dropped");
oe_cause_a: assert property ($rose(q_oe) |-> idle_ff < 5'h10)
    else $error("q_oe without read");
endmodule
bind ddr_sram_read_port_interface sram_port_props i_props (.*);

/* test/mem_ctrl_model.sv */
`timescale 1ns/10ps
module mem_ctrl_model
    import sram_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    output logic k_clk,
    output logic k_clk_n,
    output logic c_clk,
    output logic c_clk_n,
    output logic [ADDR_W-1:0] addr,
    output logic read_port_sel_n,
    output logic write_port_sel_n,
    output logic [DATA_W-1:0] d_in
);
int seed = 32'h7adb_204b;
int ph;
logic slot, sel;
logic [ADDR_W-1:0] a;
logic [ADDR_W-1:0] wa[$];
always @(negedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        {k_clk, k_clk_n, c_clk, c_clk_n, slot} <= 5'h00;
        {read_port_sel_n, write_port_sel_n} <= 2'h3;
        addr <= ADDR_RST;
        d_in <= DATA_RST;
        ph = 0;
    end else begin
        {c_clk, c_clk_n} <= {k_clk, k_clk_n};
        ph = ph + 1;
        if (ph == 1) read_port_sel_n <= 1'b1;
        if (ph == 3) begin
            ph = 0;
            k_clk <= !k_clk;
            k_clk_n <= k_clk;
            d_in <= DATA_W'($random(seed));
            if (!k_clk) begin
                sel = $random(seed) % 4 != 0;
                a = ADDR_W'($random(seed));
                // Reads only hit words whose writes are complete
                if (!slot && wa.size() > 1) a = wa[$unsigned($random(seed)) % (wa.size() - 1)];
                if (slot && sel) wa.push_back(a);
                addr <= a;
                read_port_sel_n <= slot || wa.size() < 2 || !sel;
                write_port_sel_n <= !slot || !sel;
                slot <= !slot;
            end
        end
    end
end
endmodule

/* test/tb_ddr_sram_read_port_interface.sv */
`timescale 1ns/10ps
module tb_ddr_sram_read_port_interface
    import sram_port_pkg::*;
;
logic ref_clk = 1'b0;
logic rst_n, single_clk_mode, k_clk, k_clk_n, c_clk, c_clk_n, q_oe;
logic read_port_sel_n, write_port_sel_n, slot, due1, due2, lp;
logic [ADDR_W-1:0] addr, wadr;
logic [DATA_W-1:0] d_in, q_out, val1, val2;
logic [DATA_W-1:0] mem [logic [ADDR_W+1:0]];
logic [DATA_W-1:0] exp_q[$];
int rdy_q[$];
logic [3:0] prev, rs;
int err_total, samples_checked, cyc, wbeat, quiet;
ddr_sram_read_port_interface i_ddr_sram_read_port_interface (.*);
mem_ctrl_model i_mem_ctrl_model (.*);
always #25 ref_clk = !ref_clk;
task automatic check(logic [DATA_W-1:0] got, logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
        err_total++;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task complete_run;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
////////////////////////////////////////////////////////////////
always @(posedge ref_clk) begin
    if (++cyc == 9000) begin
        err_total++;
        complete_run;
    end else if (!rst_n) begin
        prev = 4'h0;
        slot = 1'b0;
        due1 = 1'b0;
        due2 = 1'b0;
        wbeat = 4;
        quiet = 0;
        exp_q.delete();
        rdy_q.delete();
    end else begin
        rs = {k_clk, k_clk_n, c_clk, c_clk_n} & ~prev;
        prev = {k_clk, k_clk_n, c_clk, c_clk_n};
        {due2, val2} = {due1, val1};
        lp = single_clk_mode ? rs[3] : rs[1];
        // A beat can leave only once it sits in the buffer
        due1 = (lp | (single_clk_mode ? rs[2] : rs[0])) && exp_q.size() > 0 && rdy_q[0] <= cyc;
        quiet = due1 ? 0 : quiet + 1;
        if (due1) begin
            val1 = exp_q.pop_front();
            void'(rdy_q.pop_front());
        end
        if ((rs[3] | rs[2]) && wbeat < 4) mem[{wbeat[1:0], wadr}] = d_in;
        if ((rs[3] | rs[2]) && wbeat < 4) wbeat++;
        if (rs[3]) begin
            if (!slot && !read_port_sel_n)
                for (int i = 0; i < 4; i++) begin
                    exp_q.push_back(mem[{i[1:0], addr}]);
                    rdy_q.push_back(cyc + 2 + i);
                end
            if (slot && !write_port_sel_n) begin
                wadr = addr;
                wbeat = 0;
            end
            slot = !slot;
        end
    end
end
always @(negedge ref_clk) begin
    if (rst_n && due2) check(q_out, val2);
    if (rst_n && due2) check(DATA_W'(q_oe), DATA_W'(1));
    if (rst_n && quiet > 20) check(DATA_W'(q_oe), DATA_W'(0));
end
initial begin
    rst_n = 1'b0;
    single_clk_mode = 1'b0;
    for (int m = 0; m < 2; m++) begin
        @(negedge ref_clk);
        rst_n = 1'b0;
        single_clk_mode = m[0];
        repeat (8) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3000) @(negedge ref_clk);
    end
    complete_run;
end
endmodule
